// ### logic/dhc_defines.svh
// constants, field widths, timing counts and reset values for the dpll holdover and hitless control
`ifndef DHC_DEFINES_SVH
`define DHC_DEFINES_SVH

`define DHC_FREQ_W         40
`define DHC_PHASE_W        32
`define DHC_MODE_W         5
`define DHC_PROG_W         24
`define DHC_FINE_W         64

`define DHC_MODE_FREERUN   5'h01
`define DHC_MODE_HOLDOVER  5'h02

`define DHC_L3_SEL_FREE    3'h1
`define DHC_L3_SEL_HOLD    3'h2
`define DHC_L3_SEL_LOCK    3'h4

`define DHC_CLK_HZ         125000000
`define DHC_TICK_S         1
`define DHC_TICK_CYCLES    (`DHC_TICK_S * `DHC_CLK_HZ)

`define DHC_HIST_DEPTH     64
`define DHC_HIST_1S        1
`define DHC_HIST_8S        8
`define DHC_HIST_64S       64

`define DHC_AVG_FRAC       24
`define DHC_AVG_SH0        6'd20
`define DHC_AVG_SH1        6'd17
`define DHC_AVG_SH2        6'd14
`define DHC_AVG_SH3        6'd10

`define DHC_FREQ_RANGE     40'sd545571700000

`define DHC_PH_FRAC        32
`define DHC_SLOPE_SH       20
`define DHC_SLOPE_K        ((64'd1 << (`DHC_PH_FRAC + `DHC_SLOPE_SH)) / 64'(`DHC_CLK_HZ))
`define DHC_SLOPE_R0       32'd61000000
`define DHC_SLOPE_R1       32'd885000
`define DHC_SLOPE_R2       32'd7500000
`define DHC_SLOPE_R3       32'd1400000000
`define DHC_SLOPE_R4       32'd1000
`define DHC_SLOPE_R5       32'd5000
`define DHC_SLOPE_R6       32'd10000
`define DHC_PROG_FS_PS     64'd1484361400

`define DHC_MAN_RST        1'b0
`define DHC_AUTO_AVG_RST   1'b1
`define DHC_HIST_RST       2'h0
`define DHC_AVG_SEL_RST    2'h1
`define DHC_READ_AVG_RST   1'b0
`define DHC_HS_EN_RST      1'b0
`define DHC_HS_FRZ_RST     1'b0
`define DHC_SLOPE_SEL_RST  3'h7
`define DHC_SLOPE_VAL_RST  24'h000000
`define DHC_LIMIT_RST      `DHC_FREQ_RANGE
`define DHC_MANUAL_RST     40'sh0000000000
`define DHC_MASK_RST       1'b0
`define DHC_L3_PDN_RST     1'b1

`endif

// ### logic/dhc_pkg.sv
// types shared by the dpll holdover and hitless control block
package dhc_pkg;
`include "dhc_defines.svh"

    typedef logic signed [`DHC_FREQ_W-1:0]  dhc_freq_t;
    typedef logic signed [`DHC_PHASE_W-1:0] dhc_phase_t;
    typedef logic [`DHC_MODE_W-1:0]         dhc_mode_t;

    typedef enum logic [2:0] {
        DHC_L3_FREE = 3'b001,
        DHC_L3_HOLD = 3'b010,
        DHC_L3_LOCK = 3'b100
    } dhc_l3_state_e;

    typedef struct packed {
        logic                   man_holdover;
        logic                   auto_avg;
        logic [1:0]             hist_sel;
        logic [1:0]             avg_sel;
        logic                   read_avg;
        logic                   hs_en;
        logic                   hs_freeze;
        logic [2:0]             phase_slope_limit_sel;
        logic [`DHC_PROG_W-1:0] phase_slope_limit_value;
        dhc_freq_t              freq_limit;
        dhc_freq_t              manual_freq;
        logic                   mode_chg_mask;
    } dhc_cfg_s;

    typedef struct packed {
        dhc_mode_t  mode;
        logic [2:0] ref_sel;
        logic       freq_valid;
        dhc_freq_t  loop_freq;
        dhc_phase_t phase_err;
    } dhc_loop_in_s;

    typedef struct packed {
        dhc_freq_t  freq_cmd;
        dhc_freq_t  read_freq;
        dhc_phase_t phase_adj;
        logic       phase_lock_en;
        logic       phase_build_out_event;
        logic       loop_mode_change_flag;
    } dhc_loop_out_s;

    localparam dhc_cfg_s DHC_CFG_RST = '{
        man_holdover:            `DHC_MAN_RST,
        auto_avg:                `DHC_AUTO_AVG_RST,
        hist_sel:                `DHC_HIST_RST,
        avg_sel:                 `DHC_AVG_SEL_RST,
        read_avg:                `DHC_READ_AVG_RST,
        hs_en:                   `DHC_HS_EN_RST,
        hs_freeze:               `DHC_HS_FRZ_RST,
        phase_slope_limit_sel:   `DHC_SLOPE_SEL_RST,
        phase_slope_limit_value: `DHC_SLOPE_VAL_RST,
        freq_limit:              `DHC_LIMIT_RST,
        manual_freq:             `DHC_MANUAL_RST,
        mode_chg_mask:           `DHC_MASK_RST
    };
endpackage

// ### logic/dhc_slope_step.sv
// phase slope limit decode: selected rate turned into a per-cycle fine phase step
`timescale 1ns/1ps
`include "dhc_defines.svh"
module dhc_slope_step
    import dhc_pkg::*;
(
    input  wire logic [2:0]             sel_in,
    input  wire logic [`DHC_PROG_W-1:0] prog_in,
    output logic [`DHC_FINE_W-1:0]      step_out
);
    logic [31:0] rate_ps;
    logic [63:0] prod;

    // rate in ps per second; fine phase lsb is 2^-32 ps
    always_comb begin
        case (sel_in)
            3'h0: rate_ps = `DHC_SLOPE_R0;
            3'h1: rate_ps = `DHC_SLOPE_R1;
            3'h2: rate_ps = `DHC_SLOPE_R2;
            3'h3: rate_ps = `DHC_SLOPE_R3;
            3'h4: rate_ps = `DHC_SLOPE_R4;
            3'h5: rate_ps = `DHC_SLOPE_R5;
            3'h6: rate_ps = `DHC_SLOPE_R6;
            // full code spans the programmable range; zero value means no movement at all
            default: rate_ps = 32'((64'(prog_in) * `DHC_PROG_FS_PS) >> `DHC_PROG_W);
        endcase
        prod = 64'(rate_ps) * `DHC_SLOPE_K;
        step_out = prod >> `DHC_SLOPE_SH;
    end
endmodule

// ### logic/dhc_hist.sv
// history of once-per-second averaged frequency snapshots, taps at 1, 8 and 64 seconds back
`timescale 1ns/1ps
`include "dhc_defines.svh"
module dhc_hist
    import dhc_pkg::*;
#(
    parameter int DEPTH = `DHC_HIST_DEPTH
)(
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       clk_en_in,
    input  wire logic       push_in,
    input  wire dhc_freq_t  data_in,
    input  wire logic [1:0] sel_in,
    output dhc_freq_t       data_out
);
    localparam int AW = $clog2(DEPTH);

    dhc_freq_t       mem [DEPTH];
    logic [AW-1:0]   wr_q;
    logic [AW-1:0]   back;
    dhc_freq_t       data_q;

    always_comb begin
        case (sel_in)
            2'h2:    back = AW'(`DHC_HIST_8S);
            2'h3:    back = AW'(`DHC_HIST_64S);
            default: back = AW'(`DHC_HIST_1S);
        endcase
    end

    // no reset on the array: data_q samples the selected slot every enabled cycle, even before that slot is written
    always_ff @(posedge clk_in) begin
        if (clk_en_in && push_in) begin
            mem[wr_q] <= data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_q <= '0;
        end else if (clk_en_in && push_in) begin
            wr_q <= wr_q + AW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            data_q <= '0;
        end else if (clk_en_in) begin
            data_q <= mem[wr_q - back];
        end
    end

    assign data_out = data_q;
endmodule

// ### logic/dhc_ctrl.sv
// holdover acquisition, hitless build-out, slope limit and frequency clamp for two loops; third loop mode control
`timescale 1ns/1ps
`include "dhc_defines.svh"
module dhc_ctrl
    import dhc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `DHC_TICK_CYCLES,
    parameter int          LOOPS       = 2
)(
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 clk_en_in,
    input  wire logic [LOOPS-1:0]     cfg_wr_in,
    input  wire dhc_cfg_s             cfg_in,
    input  wire logic [LOOPS-1:0]     flag_clr_in,
    input  wire dhc_loop_in_s [LOOPS-1:0] loop_in,
    output dhc_loop_out_s [LOOPS-1:0] loop_out,
    output logic                      irq_out,
    input  wire logic                 loop3_pdn_wr_in,
    input  wire logic                 loop3_power_down_in,
    input  wire logic [2:0]           loop3_mode_sel_in,
    input  wire logic                 loop3_ref_selected_in,
    input  wire logic                 loop3_ref_event_in,
    output logic                      loop3_enable_out,
    output dhc_l3_state_e             loop3_state_out
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // symmetric saturation; a negative limit is treated as zero
    function automatic dhc_freq_t dhc_clamp(input dhc_freq_t x, input dhc_freq_t lim);
        dhc_freq_t l;
        l = (lim < 0) ? '0 : lim;
        if (x > l) begin
            return l;
        end else if (x < -l) begin
            return -l;
        end
        return x;
    endfunction

    function automatic logic dhc_is_idle(input dhc_mode_t m);
        return (m == `DHC_MODE_HOLDOVER) || (m == `DHC_MODE_FREERUN);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // one second tick for the history snapshots

    logic [TW-1:0] sec_cnt_q;
    logic          sec_tick;

    assign sec_tick = (sec_cnt_q == TW'(TICK_CYCLES - 1));

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sec_cnt_q <= '0;
        end else if (clk_en_in) begin
            if (sec_tick) begin
                sec_cnt_q <= '0;
            end else begin
                sec_cnt_q <= sec_cnt_q + TW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-loop logic for the first and second loops

    logic [LOOPS-1:0] irq_vec;
    logic             irq_q;

    for (genvar g = 0; g < LOOPS; g++) begin : g_loop
        dhc_cfg_s                cfg_q;
        logic signed [63:0]      acc_q;
        logic signed [63:0]      acc_diff;
        logic [5:0]              sh;
        dhc_freq_t               avg_v;
        dhc_freq_t               hist_v;
        dhc_freq_t               auto_v;
        dhc_freq_t               ho_v;
        dhc_freq_t               src_v;
        dhc_freq_t               cmd_q;
        dhc_freq_t               rd_q;
        logic                    in_hold;
        logic                    in_free;
        logic                    tracking;
        dhc_mode_t               mode_prev_q;
        logic [2:0]              ref_prev_q;
        logic                    mode_chg;
        logic                    hs_trig;
        logic                    hs_evt;
        logic                    evt_q;
        logic                    flag_q;
        logic                    lock_q;
        logic signed [63:0]      off_q;
        logic [`DHC_FINE_W-1:0]  step;
        logic signed [63:0]      step_s;

        assign in_hold  = (loop_in[g].mode == `DHC_MODE_HOLDOVER);
        assign in_free  = (loop_in[g].mode == `DHC_MODE_FREERUN);
        assign tracking = !(in_hold || in_free);

        ////////////////////////////////////////////////////////////////////////
        // configuration, loaded as one word per loop

        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                cfg_q <= DHC_CFG_RST;
            end else if (clk_en_in && cfg_wr_in[g]) begin
                cfg_q <= cfg_in;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // averaging filter: first-order iir, shift picks the bandwidth

        always_comb begin
            case (cfg_q.avg_sel)
                2'h0:    sh = `DHC_AVG_SH0;
                2'h1:    sh = `DHC_AVG_SH1;
                2'h2:    sh = `DHC_AVG_SH2;
                default: sh = `DHC_AVG_SH3;
            endcase
        end

        assign acc_diff = {loop_in[g].loop_freq, `DHC_AVG_FRAC'(0)} - acc_q;
        assign avg_v    = acc_q[63:`DHC_AVG_FRAC];

        // frozen outside tracking so holdover keeps the value from before entry
        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                acc_q <= '0;
            end else if (clk_en_in && loop_in[g].freq_valid && tracking) begin
                acc_q <= acc_q + (acc_diff >>> sh);
            end
        end

        dhc_hist #(
            .DEPTH (`DHC_HIST_DEPTH)
        ) u_hist (
            .clk_in     (clk_in),
            .reset_n_in (reset_n_in),
            .clk_en_in  (clk_en_in),
            .push_in    (sec_tick && tracking),
            .data_in    (avg_v),
            .sel_in     (cfg_q.hist_sel),
            .data_out   (hist_v)
        );

        ////////////////////////////////////////////////////////////////////////
        // holdover offset selection and frequency command

        always_comb begin
            if (cfg_q.auto_avg && (cfg_q.hist_sel != 2'h0)) begin
                auto_v = hist_v;
            end else begin
                auto_v = avg_v;
            end
            if (cfg_q.man_holdover) begin
                ho_v = cfg_q.manual_freq;
            end else begin
                ho_v = auto_v;
            end
            // free-run follows the system clock, so no offset at all
            if (in_hold) begin
                src_v = ho_v;
            end else if (in_free) begin
                src_v = '0;
            end else begin
                src_v = loop_in[g].loop_freq;
            end
        end

        // one lsb is a fixed fraction of a ppm; the range bound is counted in lsbs
        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                cmd_q <= '0;
            end else if (clk_en_in) begin
                cmd_q <= dhc_clamp(dhc_clamp(src_v, `DHC_FREQ_RANGE), cfg_q.freq_limit);
            end
        end

        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                rd_q <= '0;
            end else if (clk_en_in) begin
                if (cfg_q.read_avg) begin
                    rd_q <= dhc_clamp(auto_v, `DHC_FREQ_RANGE);
                end else begin
                    rd_q <= cfg_q.manual_freq;
                end
            end
        end

        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                lock_q <= 1'b0;
            end else if (clk_en_in) begin
                lock_q <= tracking;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // mode change flag

        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                mode_prev_q <= `DHC_MODE_FREERUN;
                ref_prev_q  <= '0;
            end else if (clk_en_in) begin
                mode_prev_q <= loop_in[g].mode;
                ref_prev_q  <= loop_in[g].ref_sel;
            end
        end

        assign mode_chg = (loop_in[g].mode != mode_prev_q);

        // a change in the clearing cycle keeps the flag set
        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                flag_q <= 1'b0;
            end else if (clk_en_in) begin
                if (mode_chg) begin
                    flag_q <= 1'b1;
                end else if (flag_clr_in[g]) begin
                    flag_q <= 1'b0;
                end
            end
        end

        assign irq_vec[g] = flag_q && cfg_q.mode_chg_mask;

        ////////////////////////////////////////////////////////////////////////
        // hitless build-out and phase pull-back

        assign hs_trig = cfg_q.hs_en
                         && ((loop_in[g].ref_sel != ref_prev_q)
                             || (dhc_is_idle(mode_prev_q) && tracking));
        assign hs_evt  = hs_trig && !cfg_q.hs_freeze;

        dhc_slope_step u_slope (
            .sel_in  (cfg_q.phase_slope_limit_sel),
            .prog_in (cfg_q.phase_slope_limit_value),
            .step_out(step)
        );

        assign step_s = $signed({1'b0, step[62:0]});

        // offset kept with 32 fractional ps bits so slow limits still move every cycle
        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                off_q <= '0;
            end else if (clk_en_in) begin
                if (hs_evt) begin
                    // full measured offset absorbed; residual is the 1 ps measurement grain
                    off_q <= {loop_in[g].phase_err, `DHC_PH_FRAC'(0)};
                end else if (!cfg_q.hs_en) begin
                    if (off_q > step_s) begin
                        off_q <= off_q - step_s;
                    end else if (off_q < -step_s) begin
                        off_q <= off_q + step_s;
                    end else begin
                        off_q <= '0;
                    end
                end
            end
        end

        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                evt_q <= 1'b0;
            end else if (clk_en_in) begin
                evt_q <= hs_evt;
            end
        end

        assign loop_out[g] = '{
            freq_cmd:              cmd_q,
            read_freq:             rd_q,
            phase_adj:             off_q[63:`DHC_PH_FRAC],
            phase_lock_en:         lock_q,
            phase_build_out_event: evt_q,
            loop_mode_change_flag: flag_q
        };
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            irq_q <= 1'b0;
        end else if (clk_en_in) begin
            irq_q <= |irq_vec;
        end
    end

    assign irq_out = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // third loop: power down and operating mode

    logic          l3_pdn_q;
    dhc_l3_state_e l3_state_q;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            l3_pdn_q <= `DHC_L3_PDN_RST;
        end else if (clk_en_in && loop3_pdn_wr_in) begin
            l3_pdn_q <= loop3_power_down_in;
        end
    end

    // reserved mode codes fall back to automatic rather than freezing the loop
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || (clk_en_in && l3_pdn_q)) begin
            l3_state_q <= DHC_L3_FREE;
        end else if (clk_en_in) begin
            case (loop3_mode_sel_in)
                `DHC_L3_SEL_FREE: begin
                    l3_state_q <= DHC_L3_FREE;
                end
                `DHC_L3_SEL_HOLD: begin
                    l3_state_q <= DHC_L3_HOLD;
                end
                `DHC_L3_SEL_LOCK: begin
                    l3_state_q <= DHC_L3_LOCK;
                end
                default: begin
                    case (l3_state_q)
                        DHC_L3_FREE: begin
                            if (loop3_ref_selected_in) begin
                                l3_state_q <= DHC_L3_LOCK;
                            end
                        end
                        DHC_L3_LOCK: begin
                            if (loop3_ref_event_in || !loop3_ref_selected_in) begin
                                l3_state_q <= DHC_L3_HOLD;
                            end
                        end
                        DHC_L3_HOLD: begin
                            if (!loop3_ref_selected_in) begin
                                l3_state_q <= DHC_L3_FREE;
                            end else if (!loop3_ref_event_in) begin
                                l3_state_q <= DHC_L3_LOCK;
                            end
                        end
                        default: begin
                            l3_state_q <= DHC_L3_FREE;
                        end
                    endcase
                end
            endcase
        end
    end

    assign loop3_enable_out = !l3_pdn_q;
    assign loop3_state_out  = l3_state_q;
endmodule

// ### testbench/dhc_ctrl_monitor.sv
// port-level assertions for the holdover and hitless control block
`timescale 1ns/1ps
module dhc_ctrl_monitor
    import dhc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 16,
    parameter int          LOOPS       = 2
)(
    input  wire logic                      clk_in,
    input  wire logic                      reset_n_in,
    input  wire logic                      clk_en_in,
    input  wire logic [LOOPS-1:0]          flag_clr_in,
    input  wire dhc_loop_in_s [LOOPS-1:0]  loop_in,
    input  wire dhc_loop_out_s [LOOPS-1:0] loop_out,
    input  wire logic                      irq_out,
    input  wire logic                      loop3_pdn_wr_in,
    input  wire logic [2:0]                loop3_mode_sel_in,
    input  wire logic                      loop3_ref_selected_in,
    input  wire logic                      loop3_ref_event_in,
    input  wire logic                      loop3_enable_out,
    input  wire dhc_l3_state_e             loop3_state_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // a power-down write in flight leaves the next state alone; free-run is only forced a cycle later
    wire logic on = loop3_enable_out && !loop3_pdn_wr_in && clk_en_in;
    wire logic au = on && loop3_mode_sel_in == 3'h0;
    ////////////////////////////////////////////////////////////////////////
    pdn_free_a: assert property ($past(!loop3_enable_out && clk_en_in) && !loop3_enable_out |-> loop3_state_out == DHC_L3_FREE)
        else $error("loop3 left free-run while powered down");
    frc_free_a: assert property (on && loop3_mode_sel_in == 3'h1 |=> loop3_state_out == DHC_L3_FREE)
        else $error("forced free-run not taken");
    frc_hold_a: assert property (on && loop3_mode_sel_in == 3'h2 |=> loop3_state_out == DHC_L3_HOLD)
        else $error("forced holdover not taken");
    frc_lock_a: assert property (on && loop3_mode_sel_in == 3'h4 |=> loop3_state_out == DHC_L3_LOCK)
        else $error("forced locked not taken");
    auto_lock_a: assert property (au && loop3_state_out == DHC_L3_FREE && loop3_ref_selected_in |=> loop3_state_out == DHC_L3_LOCK)
        else $error("selection did not lock");
    ref_loss_a: assert property (au && loop3_state_out == DHC_L3_LOCK && loop3_ref_event_in |=> loop3_state_out == DHC_L3_HOLD)
        else $error("reference event did not enter holdover");
    none_free_a: assert property (au && loop3_state_out == DHC_L3_HOLD && !loop3_ref_selected_in |=> loop3_state_out == DHC_L3_FREE)
        else $error("no selection did not free-run");
    hold_open_a: assert property (clk_en_in && loop_in[0].mode == 5'h02 |=> !loop_out[0].phase_lock_en)
        else $error("phase lock in holdover");
    flag_keep_a: assert property (loop_out[0].loop_mode_change_flag && !flag_clr_in[0] |=> loop_out[0].loop_mode_change_flag)
        else $error("mode change flag not sticky");
    irq_cause_a: assert property (clk_en_in && !loop_out[0].loop_mode_change_flag && !loop_out[1].loop_mode_change_flag |=> !irq_out)
        else $error("interrupt without flag");
endmodule
bind dhc_ctrl dhc_ctrl_monitor #(.TICK_CYCLES(TICK_CYCLES), .LOOPS(LOOPS)) i_mon (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .flag_clr_in(flag_clr_in), .loop_in(loop_in),
    .loop_out(loop_out), .irq_out(irq_out), .loop3_pdn_wr_in(loop3_pdn_wr_in), .loop3_mode_sel_in(loop3_mode_sel_in),
    .loop3_ref_selected_in(loop3_ref_selected_in), .loop3_ref_event_in(loop3_ref_event_in),
    .loop3_enable_out(loop3_enable_out), .loop3_state_out(loop3_state_out));

// ### testbench/dhc_ctrl_bench.sv
// self-checking bench for the holdover and hitless control block
`timescale 1ns/1ps
module dhc_ctrl_bench;
    import dhc_pkg::*;
    logic               clk_in = 1'b0;
    logic               reset_n_in = 1'b0;
    logic [1:0]         wr = 2'h0;
    logic [1:0]         clr = 2'h0;
    logic [2:0]         sel = 3'h0;
    logic               pwr_wr = 1'b0;
    logic               pdn = 1'b1;
    logic               refs = 1'b0;
    logic               ev = 1'b0;
    logic               irq;
    logic               en;
    dhc_cfg_s           cfg = DHC_CFG_RST;
    dhc_loop_in_s [1:0] li = '0;
    dhc_loop_out_s [1:0] lo;
    dhc_l3_state_e      st;
    int                 bad_count = 0;
    int                 comparisons = 0;
    initial forever #4 clk_in = ~clk_in;
    // short tick keeps the history pushes inside a brief run
    dhc_ctrl #(.TICK_CYCLES(16)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
        .cfg_wr_in(wr), .cfg_in(cfg), .flag_clr_in(clr), .loop_in(li), .loop_out(lo), .irq_out(irq),
        .loop3_pdn_wr_in(pwr_wr), .loop3_power_down_in(pdn), .loop3_mode_sel_in(sel),
        .loop3_ref_selected_in(refs), .loop3_ref_event_in(ev), .loop3_enable_out(en), .loop3_state_out(st));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_f(dhc_freq_t got, dhc_freq_t exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t freq %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t value %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic put_cfg(dhc_cfg_s c);
        @(posedge clk_in);
        cfg <= c;
        wr <= 2'h1;
        @(posedge clk_in);
        wr <= 2'h0;
        step(2);
    endtask
    task automatic drive(logic [4:0] m, logic [2:0] r, dhc_freq_t f, dhc_phase_t p);
        @(posedge clk_in);
        li[0].mode <= m;
        li[0].ref_sel <= r;
        li[0].loop_freq <= f;
        li[0].phase_err <= p;
        step(3);
    endtask
    task automatic holdover_src;
        dhc_cfg_s c = DHC_CFG_RST;
        c.man_holdover = 1'b1;
        c.manual_freq = 40'sh12345;
        put_cfg(c);
        chk_f(lo[0].read_freq, 40'sh12345);
        drive(5'h02, 3'h0, 40'sh7777, 32'sh0);
        chk_f(lo[0].freq_cmd, 40'sh12345);
        chk_b(lo[0].phase_lock_en, 32'h0);
        c.freq_limit = 40'sh1000;
        c.read_avg = 1'b1;
        c.avg_sel = 2'h3;
        put_cfg(c);
        drive(5'h04, 3'h0, 40'sh7777, 32'sh0);
        chk_f(lo[0].freq_cmd, 40'sh1000);
        drive(5'h04, 3'h0, -40'sh7777, 32'sh0);
        chk_f(lo[0].freq_cmd, -40'sh1000);
        @(posedge clk_in);
        li[0].freq_valid <= 1'b1;
        @(posedge clk_in);
        li[0].freq_valid <= 1'b0;
        step(2);
        chk_f(lo[0].read_freq, -40'sd30);
    endtask
    task automatic hitless;
        dhc_cfg_s c = DHC_CFG_RST;
        int i;
        c.hs_en = 1'b1;
        put_cfg(c);
        @(posedge clk_in);
        li[0].phase_err <= 32'sd123;
        li[0].ref_sel <= 3'h1;
        for (i = 0; i < 8 && lo[0].phase_build_out_event !== 1'b1; i++) step(1);
        if (i == 8) begin
            bad_count++;
            $display("Error %0t no build-out event", $time);
            report_and_stop();
        end
        step(1);
        chk_b(lo[0].phase_adj, 32'd123);
        chk_b(lo[0].phase_build_out_event, 32'h0);
        drive(5'h02, 3'h1, 40'sh0, 32'sd55);
        drive(5'h04, 3'h1, 40'sh0, 32'sd55);
        chk_b(lo[0].phase_adj, 32'd55);
        c.hs_freeze = 1'b1;
        put_cfg(c);
        drive(5'h04, 3'h2, 40'sh0, 32'sd77);
        chk_b(lo[0].phase_adj, 32'd55);
        c = DHC_CFG_RST;
        put_cfg(c);
        step(20);
        chk_b(lo[0].phase_adj, 32'd55);
        c.phase_slope_limit_sel = 3'h3;
        c.mode_chg_mask = 1'b1;
        put_cfg(c);
        step(40);
        chk_b(lo[0].phase_adj, 32'd0);
        chk_b(irq, 32'h1);
        @(posedge clk_in);
        clr <= 2'h3;
        @(posedge clk_in);
        clr <= 2'h0;
        step(2);
        chk_b(lo[0].loop_mode_change_flag, 32'h0);
        chk_b(irq, 32'h0);
        drive(5'h02, 3'h2, 40'sh0, 32'sh0);
        chk_b(irq, 32'h1);
    endtask
    task automatic loop3;
        dhc_l3_state_e xs [5] = '{DHC_L3_HOLD, DHC_L3_FREE, DHC_L3_LOCK, DHC_L3_HOLD, DHC_L3_LOCK};
        logic [4:0] rv = 5'b11100;
        logic [4:0] evv = 5'b01000;
        int i;
        @(posedge clk_in);
        pdn <= 1'b0;
        pwr_wr <= 1'b1;
        @(posedge clk_in);
        pwr_wr <= 1'b0;
        step(1);
        chk_b(en, 32'h1);
        for (i = 0; i < 3; i++) begin
            @(posedge clk_in);
            sel <= 3'(1 << i);
            step(2);
            chk_b(st, 32'(1 << i));
        end
        for (i = 0; i < 5; i++) begin
            @(posedge clk_in);
            sel <= 3'h0;
            refs <= rv[i];
            ev <= evv[i];
            @(posedge clk_in);
            ev <= 1'b0;
            #1;
            chk_b(st, xs[i]);
        end
    endtask
    initial begin
        li[0].mode = 5'h01;
        li[1].mode = 5'h01;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        step(1);
        chk_b(en, 32'h0);
        chk_b(st, DHC_L3_FREE);
        holdover_src();
        hitless();
        loop3();
        report_and_stop();
    end
endmodule
